// [rtsc_core.sv]
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
// Functional notes
// - conditioning code zero or fourteen passes the octet unchanged
// - code ten replaces the octet with the mu-law milliwatt sequence
// - code eleven inverts only the most significant bit
// - code twelve inverts every bit except the most significant
// - code thirteen sends generator output; type bit picks PRBS15 or quasi-random
// - code fifteen is a D/E slot; three-bit select picks the source
// - thirty-two eight-bit user codes in one contiguous address range
// - user codes reset to all ones and replace the octet at code four
// - substitute enable bit 6 replaces received ABCD bits; resets clear
// - substitution touches only PCM output, never array or signaling pin
// - substitution format 00 replaces all signaling bits with ones
// - overhead enable bit 5 sends array contents to overhead pin
// - debounce bit 4 updates array only after two equal superframes
// - debounced, differing consecutive superframes leave array and pin unchanged
// - without debounce array and pin follow every received change
// - thirty-two signaling control registers in one contiguous range
module rtsc_core (
    input  wire logic        ref_clk_in,
    input  wire logic        reset_in,
    input  wire logic [11:0] addr_in,
    input  wire logic [7:0]  wr_data_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [7:0]  rd_data_out,
    input  wire logic        octet_valid_in,
    input  wire logic [4:0]  octet_slot_in,
    input  wire logic [7:0]  octet_in,
    input  wire logic        octet_has_sig_in,
    input  wire logic [7:0]  de_octet_in,
    input  wire logic [2:0]  de_slot_source_select_in,
    input  wire logic        pattern_type_select_in,
    input  wire logic [6:0]  sig_substitute_values_in,
    input  wire logic        sig_valid_in,
    input  wire logic [4:0]  sig_slot_in,
    input  wire logic [3:0]  sig_abcd_in,
    output logic      [7:0]  rx_serial_pcm_out,
    output logic             pcm_valid_out,
    output logic      [3:0]  rx_signaling_pin_out,
    output logic             sig_strobe_out,
    output logic      [3:0]  rx_overhead_pin_out,
    output logic             oh_strobe_out,
    output logic      [4:0]  sig_slot_out
);

    typedef struct packed {
        logic [31:0][3:0] cond;
        logic [31:0][7:0] user;
        logic [31:0][6:0] sctl;
        logic [31:0][3:0] prev;
        logic [31:0][3:0] arr;
        logic [14:0]      prbs;
        logic [19:0]      quasi;
        logic [2:0]       mw_ph;
        logic [7:0]       pcm;
        logic             pcm_vld;
        logic [3:0]       sig;
        logic [3:0]       oh;
        logic [4:0]       sig_slot;
        logic             sig_stb;
        logic             oh_stb;
        logic [7:0]       rdata;
    } rtsc_state_type;

    localparam rtsc_state_type RST_STATE = '{
        cond:     {32{rtsc_pkg::COND_RST}},
        user:     {32{rtsc_pkg::USER_RST}},
        sctl:     {32{rtsc_pkg::SCTL_RST}},
        prev:     {32{rtsc_pkg::ARR_RST}},
        arr:      {32{rtsc_pkg::ARR_RST}},
        prbs:     rtsc_pkg::PRBS_SEED,
        quasi:    rtsc_pkg::QUASI_SEED,
        default:  '0
    };

    rtsc_state_type st_r;
    rtsc_state_type st_nxt;

    // address to {hit, slot}
    function automatic logic [5:0] map_slot(input logic [11:0] a, input logic [11:0] base);
        logic [11:0] d;
        d        = a - base;
        map_slot = {(a >= base) && (d < rtsc_pkg::SLOT_SPAN), d[4:0]};
    endfunction : map_slot

    function automatic logic [14:0] prbs_step8(input logic [14:0] s);
        logic [14:0] v;
        v = s;
        for (int i = 0; i < 8; i++) begin
            v = {v[13:0], v[14] ^ v[13]};
        end
        prbs_step8 = v;
    endfunction : prbs_step8

    function automatic logic [19:0] quasi_step8(input logic [19:0] s);
        logic [19:0] v;
        v = s;
        for (int i = 0; i < 8; i++) begin
            v = {v[18:0], v[19] ^ v[16]};
        end
        quasi_step8 = v;
    endfunction : quasi_step8

    logic [5:0] wr_map_c, wr_map_u, wr_map_s;
    logic [5:0] rd_map_c, rd_map_u, rd_map_s, rd_map_a;
    logic [3:0] cur_cond;
    logic [6:0] cur_sctl;
    logic [7:0] oct;
    logic [7:0] mw_alaw;
    logic [7:0] mw_mulaw;
    logic [3:0] sub_abcd;
    logic [6:0] sig_ctl;
    logic [3:0] sig_prev;

    assign cur_cond = st_r.cond[octet_slot_in];
    assign cur_sctl = st_r.sctl[octet_slot_in];
    assign sig_ctl  = st_r.sctl[sig_slot_in];
    assign sig_prev = st_r.prev[sig_slot_in];
    assign mw_alaw  = rtsc_pkg::ALAW_SEQ[8'(st_r.mw_ph) * 8 +: 8];
    assign mw_mulaw = rtsc_pkg::MULAW_SEQ[8'(st_r.mw_ph) * 8 +: 8];

    always_comb begin
        st_nxt   = st_r;
        wr_map_c = map_slot(addr_in, rtsc_pkg::COND_BASE);
        wr_map_u = map_slot(addr_in, rtsc_pkg::USER_BASE);
        wr_map_s = map_slot(addr_in, rtsc_pkg::SCTL_BASE);
        rd_map_c = wr_map_c;
        rd_map_u = wr_map_u;
        rd_map_s = wr_map_s;
        rd_map_a = map_slot(addr_in, rtsc_pkg::ARR_BASE);
        oct      = octet_in;
        sub_abcd = 4'h0;
        // register writes
        if (wr_in) begin
            if (wr_map_c[5]) begin
                st_nxt.cond[wr_map_c[4:0]] = wr_data_in[3:0];
            end
            if (wr_map_u[5]) begin
                st_nxt.user[wr_map_u[4:0]] = wr_data_in;
            end
            if (wr_map_s[5]) begin
                st_nxt.sctl[wr_map_s[4:0]] = wr_data_in[6:0];
            end
        end
        // register reads, answer only in the next cycle
        st_nxt.rdata = 8'h00;
        if (rd_in) begin
            if (rd_map_c[5]) begin
                st_nxt.rdata = {4'h0, st_r.cond[rd_map_c[4:0]]};
            end else if (rd_map_u[5]) begin
                st_nxt.rdata = st_r.user[rd_map_u[4:0]];
            end else if (rd_map_s[5]) begin
                st_nxt.rdata = {1'b0, st_r.sctl[rd_map_s[4:0]]};
            end else if (rd_map_a[5]) begin
                st_nxt.rdata = {4'h0, st_r.arr[rd_map_a[4:0]]};
            end
        end
        // octet conditioning, per slot code
        case (cur_cond)
            rtsc_pkg::CC_PASS,
            rtsc_pkg::CC_PASS2:    oct = octet_in;
            rtsc_pkg::CC_INV_ALL:  oct = octet_in ^ rtsc_pkg::MASK_ALL;
            rtsc_pkg::CC_INV_EVEN: oct = octet_in ^ rtsc_pkg::MASK_EVEN;
            rtsc_pkg::CC_INV_ODD:  oct = octet_in ^ rtsc_pkg::MASK_ODD;
            rtsc_pkg::CC_USER:     oct = st_r.user[octet_slot_in];
            rtsc_pkg::CC_BUSY:     oct = rtsc_pkg::BUSY_CODE;
            rtsc_pkg::CC_VACANT:   oct = rtsc_pkg::VACANT_CODE;
            rtsc_pkg::CC_BUSY_TS:  oct = {rtsc_pkg::BUSY_TS_HEAD, octet_slot_in};
            rtsc_pkg::CC_MOOF:     oct = rtsc_pkg::MOOF_CODE;
            rtsc_pkg::CC_ALAW:     oct = mw_alaw;
            rtsc_pkg::CC_MULAW:    oct = mw_mulaw;
            rtsc_pkg::CC_INV_MSB:  oct = octet_in ^ rtsc_pkg::MASK_MSB;
            rtsc_pkg::CC_INV_LOW:  oct = octet_in ^ rtsc_pkg::MASK_LOW;
            rtsc_pkg::CC_PRBS: begin
                oct = pattern_type_select_in ? st_r.quasi[19:12] : st_r.prbs[14:7];
            end
            rtsc_pkg::CC_DE: begin
                oct = (de_slot_source_select_in == rtsc_pkg::DE_SRC_RX) ? octet_in
                                                                        : de_octet_in;
            end
            default:               oct = octet_in;
        endcase
        // signaling substitution on the pcm copy only
        case (cur_sctl[rtsc_pkg::SCTL_FMT_LSB +: 2])
            rtsc_pkg::FMT_ONES: sub_abcd = rtsc_pkg::SIG_ONES;
            rtsc_pkg::FMT_ABCD: sub_abcd = sig_substitute_values_in[3:0];
            rtsc_pkg::FMT_AB:   sub_abcd = {sig_substitute_values_in[5:4], oct[1:0]};
            rtsc_pkg::FMT_A:    sub_abcd = {sig_substitute_values_in[6], oct[2:0]};
            default:            sub_abcd = oct[3:0];
        endcase
        if (octet_has_sig_in && cur_sctl[rtsc_pkg::SCTL_SUB_BIT]) begin
            oct[3:0] = sub_abcd;
        end
        st_nxt.pcm_vld = octet_valid_in;
        if (octet_valid_in) begin
            st_nxt.pcm = oct;
            if (cur_cond == rtsc_pkg::CC_ALAW || cur_cond == rtsc_pkg::CC_MULAW) begin
                st_nxt.mw_ph = st_r.mw_ph + 3'h1;
            end
            if (cur_cond == rtsc_pkg::CC_PRBS) begin
                if (pattern_type_select_in) begin
                    st_nxt.quasi = quasi_step8(st_r.quasi);
                end else begin
                    st_nxt.prbs = prbs_step8(st_r.prbs);
                end
            end
        end
        // signaling array, debounce and pins
        st_nxt.sig_stb = 1'b0;
        st_nxt.oh_stb  = 1'b0;
        st_nxt.oh      = 4'h0;
        if (sig_valid_in) begin
            st_nxt.prev[sig_slot_in] = sig_abcd_in;
            if (!sig_ctl[rtsc_pkg::SCTL_DEB_BIT]) begin
                st_nxt.arr[sig_slot_in] = sig_abcd_in;
            end else if (sig_abcd_in == sig_prev) begin
                st_nxt.arr[sig_slot_in] = sig_abcd_in;
            end
            st_nxt.sig      = st_nxt.arr[sig_slot_in];
            st_nxt.sig_slot = sig_slot_in;
            st_nxt.sig_stb  = 1'b1;
            if (sig_ctl[rtsc_pkg::SCTL_OH_BIT]) begin
                st_nxt.oh     = st_nxt.arr[sig_slot_in];
                st_nxt.oh_stb = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            st_r <= RST_STATE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data_out          = st_r.rdata;
    assign rx_serial_pcm_out    = st_r.pcm;
    assign pcm_valid_out        = st_r.pcm_vld;
    assign rx_signaling_pin_out = st_r.sig;
    assign sig_strobe_out       = st_r.sig_stb;
    assign rx_overhead_pin_out  = st_r.oh;
    assign oh_strobe_out        = st_r.oh_stb;
    assign sig_slot_out         = st_r.sig_slot;

    // checks
    logic sub_now;
    assign sub_now = octet_has_sig_in && cur_sctl[rtsc_pkg::SCTL_SUB_BIT];

    a_pass_through: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (octet_valid_in && !sub_now && (cur_cond == 4'h0 || cur_cond == 4'he))
        |=> (pcm_valid_out && rx_serial_pcm_out == $past(octet_in)))
        else $error("pass-through octet altered");

    a_mulaw_pattern: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (octet_valid_in && !sub_now && cur_cond == 4'ha)
        |=> (rx_serial_pcm_out == $past(mw_mulaw)))
        else $error("milliwatt octet wrong");

    a_msb_invert: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (octet_valid_in && !sub_now && cur_cond == 4'hb)
        |=> (rx_serial_pcm_out == {~$past(octet_in[7]), $past(octet_in[6:0])}))
        else $error("msb inversion wrong");

    a_low_invert: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (octet_valid_in && !sub_now && cur_cond == 4'hc)
        |=> (rx_serial_pcm_out == {$past(octet_in[7]), ~$past(octet_in[6:0])}))
        else $error("low bits inversion wrong");

    a_user_code: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (octet_valid_in && !sub_now && cur_cond == 4'h4)
        |=> (rx_serial_pcm_out == $past(st_r.user[octet_slot_in])))
        else $error("user code not substituted");

    a_sub_ones: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (octet_valid_in && sub_now && cur_sctl[3:2] == 2'b00)
        |=> (rx_serial_pcm_out[3:0] == 4'hf))
        else $error("ones substitution missing");

    a_pin_unsubst: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (sig_valid_in && !sig_ctl[4])
        |=> (sig_strobe_out && rx_signaling_pin_out == $past(sig_abcd_in)))
        else $error("signaling pin not the received value");

    a_oh_gate: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        sig_valid_in |=> (oh_strobe_out == $past(sig_ctl[5]))
        && (oh_strobe_out ? rx_overhead_pin_out == rx_signaling_pin_out
                          : rx_overhead_pin_out == 4'h0))
        else $error("overhead output gating wrong");

    a_deb_hold: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (sig_valid_in && sig_ctl[4] && sig_abcd_in != sig_prev)
        |=> (rx_signaling_pin_out == $past(st_r.arr[sig_slot_in])))
        else $error("debounce let a change through");

    a_deb_take: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (sig_valid_in && sig_ctl[4] && sig_abcd_in == sig_prev)
        |=> (rx_signaling_pin_out == $past(sig_abcd_in)))
        else $error("stable signaling not taken");

    a_sctl_readback: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (wr_in && addr_in[11:5] == 7'h1d) ##1 (rd_in && addr_in == $past(addr_in))
        |=> (rd_data_out == {1'b0, $past(wr_data_in[6:0], 2)}))
        else $error("signaling control readback wrong");

    a_user_readback: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (wr_in && addr_in[11:5] == 7'h1c) ##1 (rd_in && addr_in == $past(addr_in))
        |=> (rd_data_out == $past(wr_data_in, 2)))
        else $error("user code readback wrong");

    a_prbs_octet: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (octet_valid_in && !sub_now && cur_cond == 4'hd)
        |=> (rx_serial_pcm_out == $past(pattern_type_select_in ? st_r.quasi[19:12]
                                                               : st_r.prbs[14:7])))
        else $error("generator octet wrong");

    a_de_source: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (octet_valid_in && !sub_now && cur_cond == 4'hf)
        |=> (rx_serial_pcm_out == (($past(de_slot_source_select_in) == 3'h0) ? $past(octet_in)
                                                                              : $past(de_octet_in))))
        else $error("d/e slot source wrong");

    a_sub_values: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (octet_valid_in && sub_now && cur_sctl[3:2] == 2'b01)
        |=> (rx_serial_pcm_out[3:0] == $past(sig_substitute_values_in[3:0])))
        else $error("abcd substitution values wrong");

    a_sub_upper: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (octet_valid_in && sub_now && (cur_cond == 4'h0 || cur_cond == 4'he))
        |=> (rx_serial_pcm_out[7:4] == $past(octet_in[7:4])))
        else $error("substitution touched upper bits");

    a_arr_follow: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (sig_valid_in && !sig_ctl[4])
        |=> (st_r.arr[$past(sig_slot_in)] == $past(sig_abcd_in)))
        else $error("array did not follow received signaling");

    a_sig_slot: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        sig_valid_in
        |=> (sig_strobe_out && sig_slot_out == $past(sig_slot_in)))
        else $error("signaling strobe or slot wrong");

endmodule : rtsc_core

// [rtsc_pkg.sv]
package rtsc_pkg;
    localparam int           NSLOT         = 32;
    localparam int           ADDR_W        = 12;
    // register map, byte addresses of slot 0
    localparam logic [11:0]  COND_BASE     = 12'h300;
    localparam logic [11:0]  USER_BASE     = 12'h380;
    localparam logic [11:0]  SCTL_BASE     = 12'h3a0;
    localparam logic [11:0]  ARR_BASE      = 12'h500;
    localparam logic [11:0]  SLOT_SPAN     = 12'h020;
    // reset values
    localparam logic [3:0]   COND_RST      = 4'h0;
    localparam logic [7:0]   USER_RST      = 8'hff;
    localparam logic [6:0]   SCTL_RST      = 7'h00;
    localparam logic [3:0]   ARR_RST       = 4'h0;
    // signaling control fields
    localparam int           SCTL_SUB_BIT  = 6;
    localparam int           SCTL_OH_BIT   = 5;
    localparam int           SCTL_DEB_BIT  = 4;
    localparam int           SCTL_FMT_LSB  = 2;
    localparam logic [1:0]   FMT_ONES      = 2'h0;
    localparam logic [1:0]   FMT_ABCD      = 2'h1;
    localparam logic [1:0]   FMT_AB        = 2'h2;
    localparam logic [1:0]   FMT_A         = 2'h3;
    localparam logic [3:0]   SIG_ONES      = 4'hf;
    // conditioning codes
    localparam logic [3:0]   CC_PASS       = 4'h0;
    localparam logic [3:0]   CC_INV_ALL    = 4'h1;
    localparam logic [3:0]   CC_INV_EVEN   = 4'h2;
    localparam logic [3:0]   CC_INV_ODD    = 4'h3;
    localparam logic [3:0]   CC_USER       = 4'h4;
    localparam logic [3:0]   CC_BUSY       = 4'h5;
    localparam logic [3:0]   CC_VACANT     = 4'h6;
    localparam logic [3:0]   CC_BUSY_TS    = 4'h7;
    localparam logic [3:0]   CC_MOOF       = 4'h8;
    localparam logic [3:0]   CC_ALAW       = 4'h9;
    localparam logic [3:0]   CC_MULAW      = 4'ha;
    localparam logic [3:0]   CC_INV_MSB    = 4'hb;
    localparam logic [3:0]   CC_INV_LOW    = 4'hc;
    localparam logic [3:0]   CC_PRBS       = 4'hd;
    localparam logic [3:0]   CC_PASS2      = 4'he;
    localparam logic [3:0]   CC_DE         = 4'hf;
    // code values
    localparam logic [7:0]   BUSY_CODE     = 8'h7f;
    localparam logic [7:0]   VACANT_CODE   = 8'hff;
    localparam logic [2:0]   BUSY_TS_HEAD  = 3'h7;
    localparam logic [7:0]   MOOF_CODE     = 8'h1a;
    localparam logic [7:0]   MASK_ALL      = 8'hff;
    localparam logic [7:0]   MASK_EVEN     = 8'haa;
    localparam logic [7:0]   MASK_ODD      = 8'h55;
    localparam logic [7:0]   MASK_MSB      = 8'h80;
    localparam logic [7:0]   MASK_LOW      = 8'h7f;
    localparam logic [63:0]  ALAW_SEQ      = 64'h34212134b4a1a1b4;
    localparam logic [63:0]  MULAW_SEQ     = 64'h1e0b0b1e9e8b8b9e;
    localparam logic [14:0]  PRBS_SEED     = 15'h7fff;
    localparam logic [19:0]  QUASI_SEED    = 20'hfffff;
    localparam logic [2:0]   DE_SRC_RX     = 3'h0;
endpackage : rtsc_pkg

// [rtsc_backplane_model.sv]
`timescale 1ns/1ps
// backplane receiver: captures each pcm octet and overhead nibble it is handed
module rtsc_backplane_model (
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic [7:0] pcm_in,
    input  wire logic       pcm_valid_in,
    input  wire logic [3:0] oh_in,
    input  wire logic       oh_strobe_in,
    output logic      [7:0] pcm_seen_out,
    output logic      [3:0] oh_seen_out,
    output int              pcm_cnt_out,
    output int              oh_cnt_out
);
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pcm_seen_out <= 8'h00;
            oh_seen_out  <= 4'h0;
            pcm_cnt_out  <= 0;
            oh_cnt_out   <= 0;
        end else begin
            if (pcm_valid_in) begin
                pcm_seen_out <= pcm_in;
                pcm_cnt_out  <= pcm_cnt_out + 1;
            end
            if (oh_strobe_in) begin
                oh_cnt_out  <= oh_cnt_out + 1;
                oh_seen_out <= oh_in;
            end
        end
    end
endmodule : rtsc_backplane_model

// [rtsc_core_tb_top.sv]
`timescale 1ns/1ps
module rtsc_core_tb_top;
    logic        ref_clk_in, reset_in, wr_in, rd_in, octet_valid_in, octet_has_sig_in;
    logic        pattern_type_select_in, sig_valid_in, pcm_valid_out, sig_strobe_out;
    logic        oh_strobe_out;
    logic [11:0] addr_in;
    logic [7:0]  wr_data_in, rd_data_out, octet_in, de_octet_in, rx_serial_pcm_out, pcm_seen;
    logic [4:0]  octet_slot_in, sig_slot_in, sig_slot_out;
    logic [2:0]  de_slot_source_select_in;
    logic [6:0]  sig_substitute_values_in;
    logic [3:0]  sig_abcd_in, rx_signaling_pin_out, rx_overhead_pin_out, oh_seen;
    int          error_cnt, n_compared, n_sent, pcm_cnt, oh_cnt;

    rtsc_core i_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
        .octet_valid_in(octet_valid_in), .octet_slot_in(octet_slot_in), .octet_in(octet_in),
        .octet_has_sig_in(octet_has_sig_in), .de_octet_in(de_octet_in),
        .de_slot_source_select_in(de_slot_source_select_in),
        .pattern_type_select_in(pattern_type_select_in),
        .sig_substitute_values_in(sig_substitute_values_in), .sig_valid_in(sig_valid_in),
        .sig_slot_in(sig_slot_in), .sig_abcd_in(sig_abcd_in),
        .rx_serial_pcm_out(rx_serial_pcm_out), .pcm_valid_out(pcm_valid_out),
        .rx_signaling_pin_out(rx_signaling_pin_out), .sig_strobe_out(sig_strobe_out),
        .rx_overhead_pin_out(rx_overhead_pin_out), .oh_strobe_out(oh_strobe_out),
        .sig_slot_out(sig_slot_out));

    rtsc_backplane_model i_bp (.clk_in(ref_clk_in), .reset_in(reset_in),
        .pcm_in(rx_serial_pcm_out), .pcm_valid_in(pcm_valid_out), .oh_in(rx_overhead_pin_out),
        .oh_strobe_in(oh_strobe_out), .pcm_seen_out(pcm_seen), .oh_seen_out(oh_seen),
        .pcm_cnt_out(pcm_cnt),
        .oh_cnt_out(oh_cnt));

    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up

    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in    <= a;
        wr_data_in <= d;
        wr_in      <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1 d = rd_data_out;
    endtask : reg_rd

    // write immediately followed by a read of the same address
    task automatic reg_wr_rd(input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk_in);
        addr_in    <= a;
        wr_data_in <= d;
        wr_in      <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1 q = rd_data_out;
    endtask : reg_wr_rd

    task automatic send_octet(input logic [4:0] s, input logic [7:0] o, input logic hs,
                              output logic [7:0] pcm);
        @(posedge ref_clk_in);
        octet_valid_in   <= 1'b1;
        octet_slot_in    <= s;
        octet_in         <= o;
        octet_has_sig_in <= hs;
        @(posedge ref_clk_in);
        octet_valid_in <= 1'b0;
        #1 check("pcm_valid", {7'h00, pcm_valid_out}, 8'h01);
        pcm = rx_serial_pcm_out;
        n_sent++;
    endtask : send_octet

    task automatic send_sig(input logic [4:0] s, input logic [3:0] abcd);
        @(posedge ref_clk_in);
        sig_valid_in <= 1'b1;
        sig_slot_in  <= s;
        sig_abcd_in  <= abcd;
        @(posedge ref_clk_in);
        sig_valid_in <= 1'b0;
        #1 check("sig_strobe", {7'h00, sig_strobe_out}, 8'h01);
        check("sig_slot", {3'h0, sig_slot_out}, {3'h0, s});
    endtask : send_sig

    task automatic t_regs;
        logic [7:0] d;
        reg_rd(rtsc_pkg::USER_BASE, d);
        check("user0_rst", d, 8'hff);
        reg_rd(rtsc_pkg::USER_BASE + 12'h01f, d);
        check("user31_rst", d, 8'hff);
        reg_rd(rtsc_pkg::SCTL_BASE + 12'h01f, d);
        check("sctl31_rst", d, 8'h00);
        reg_wr_rd(rtsc_pkg::SCTL_BASE + 12'h01f, 8'h70, d);
        check("sctl31", d, 8'h70);
        reg_wr_rd(rtsc_pkg::USER_BASE + 12'h01f, 8'h3c, d);
        check("user31", d, 8'h3c);
        reg_wr(12'h3c0, 8'h55);
        reg_rd(12'h3c0, d);
        check("unmapped", d, 8'h00);
    endtask : t_regs

    task automatic t_cond;
        logic [3:0] codes [6] = '{rtsc_pkg::CC_PASS, rtsc_pkg::CC_PASS2, rtsc_pkg::CC_INV_MSB,
                                  rtsc_pkg::CC_INV_LOW, rtsc_pkg::CC_USER, rtsc_pkg::CC_DE};
        logic [7:0] exps [6] = '{8'h36, 8'h36, 8'hb6, 8'h49, 8'h5a, 8'h36};
        logic [7:0] p;
        reg_wr(rtsc_pkg::USER_BASE + 12'h005, 8'h5a);
        for (int i = 0; i < 6; i++) begin
            reg_wr(rtsc_pkg::COND_BASE + 12'(i + 1), {4'h0, codes[i]});
            send_octet(5'(i + 1), 8'h36, 1'b0, p);
            check("cond_octet", p, exps[i]);
        end
        send_octet(5'd0, 8'h81, 1'b0, p);
        check("slot0_pass", p, 8'h81);
        @(posedge ref_clk_in);
        de_slot_source_select_in <= 3'h2;
        de_octet_in              <= 8'hc3;
        send_octet(5'd6, 8'h36, 1'b0, p);
        check("de_alt", p, 8'hc3);
        reg_wr(rtsc_pkg::COND_BASE + 12'h00a, {4'h0, rtsc_pkg::CC_MULAW});
        send_octet(5'd10, 8'h00, 1'b0, p);
        check("mulaw", p & 8'h7f, 8'h1e);
        // the far side latches one edge after the octet appears
        @(posedge ref_clk_in);
        #1 check("bp_pcm", pcm_seen, p);
        check("bp_count", 8'(pcm_cnt), 8'(n_sent));
    endtask : t_cond

    task automatic t_pattern;
        logic [7:0] p;
        reg_wr(rtsc_pkg::COND_BASE + 12'h00d, {4'h0, rtsc_pkg::CC_PRBS});
        send_octet(5'd13, 8'h00, 1'b0, p);
        check("prbs_first", p, rtsc_pkg::PRBS_SEED[14:7]);
        send_octet(5'd13, 8'h00, 1'b0, p);
        check("prbs_second", p, 8'hfe);
        @(posedge ref_clk_in);
        pattern_type_select_in <= 1'b1;
        send_octet(5'd13, 8'h00, 1'b0, p);
        check("quasi_first", p, rtsc_pkg::QUASI_SEED[19:12]);
    endtask : t_pattern

    task automatic t_sig_sub;
        logic [7:0] fexp [4] = '{8'haf, 8'ha6, 8'ha9, 8'had};
        logic [7:0] p;
        @(posedge ref_clk_in);
        sig_substitute_values_in <= 7'h66;
        for (int f = 0; f < 4; f++) begin
            reg_wr(rtsc_pkg::SCTL_BASE + 12'h00c, 8'h40 | 8'(f << 2));
            send_octet(5'd12, 8'ha5, 1'b1, p);
            check("sig_sub", p, fexp[f]);
        end
        send_octet(5'd12, 8'ha5, 1'b0, p);
        check("no_sig_octet", p, 8'ha5);
        reg_wr(rtsc_pkg::SCTL_BASE + 12'h00c, 8'h04);
        send_octet(5'd12, 8'ha5, 1'b1, p);
        check("sub_off", p, 8'ha5);
        reg_wr(rtsc_pkg::SCTL_BASE + 12'h00c, 8'h44);
        send_sig(5'd12, 4'h3);
        check("sub_pin", {4'h0, rx_signaling_pin_out}, 8'h03);
        reg_rd(rtsc_pkg::ARR_BASE + 12'h00c, p);
        check("sub_array", p, 8'h03);
    endtask : t_sig_sub

    task automatic t_overhead;
        reg_wr(rtsc_pkg::SCTL_BASE + 12'h00e, 8'h20);
        send_sig(5'd14, 4'h9);
        check("oh_strobe", {7'h00, oh_strobe_out}, 8'h01);
        check("oh_data", {4'h0, rx_overhead_pin_out}, 8'h09);
        send_sig(5'd15, 4'h9);
        check("oh_off_strobe", {7'h00, oh_strobe_out}, 8'h00);
        check("oh_off_data", {4'h0, rx_overhead_pin_out}, 8'h00);
        check("pin_now", {4'h0, rx_signaling_pin_out}, 8'h09);
        check("oh_count", 8'(oh_cnt), 8'h01);
        check("bp_oh", {4'h0, oh_seen}, 8'h09);
    endtask : t_overhead

    task automatic t_debounce;
        logic [7:0] d;
        reg_wr(rtsc_pkg::SCTL_BASE + 12'h014, 8'h10);
        send_sig(5'd20, 4'h6);
        check("deb_first", {4'h0, rx_signaling_pin_out}, 8'h00);
        reg_rd(rtsc_pkg::ARR_BASE + 12'h014, d);
        check("deb_arr_first", d, 8'h00);
        send_sig(5'd20, 4'h6);
        check("deb_second", {4'h0, rx_signaling_pin_out}, 8'h06);
        send_sig(5'd20, 4'h2);
        check("deb_change", {4'h0, rx_signaling_pin_out}, 8'h06);
        reg_rd(rtsc_pkg::ARR_BASE + 12'h014, d);
        check("deb_arr_held", d, 8'h06);
        send_sig(5'd21, 4'h2);
        check("nodeb_pin", {4'h0, rx_signaling_pin_out}, 8'h02);
    endtask : t_debounce

    initial begin
        error_cnt = 0;
        n_compared = 0;
        n_sent = 0;
        reset_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 12'h000;
        wr_data_in = 8'h00;
        octet_valid_in = 1'b0;
        octet_slot_in = 5'h00;
        octet_in = 8'h00;
        octet_has_sig_in = 1'b0;
        de_octet_in = 8'h00;
        de_slot_source_select_in = 3'h0;
        pattern_type_select_in = 1'b0;
        sig_substitute_values_in = 7'h00;
        sig_valid_in = 1'b0;
        sig_slot_in = 5'h00;
        sig_abcd_in = 4'h0;
        repeat (20) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        t_regs();
        t_cond();
        t_pattern();
        t_sig_sub();
        t_overhead();
        t_debounce();
        wrap_up();
    end

    initial begin
        repeat (5000) @(posedge ref_clk_in);
        error_cnt++;
        wrap_up();
    end
endmodule : rtsc_core_tb_top
